// File: bmf_pkg.sv
// Package for the bus-matching FIFO port control block.
// Assumes a single 20 MHz system clock; all pins are sampled synchronously.
package bmf_pkg;
  localparam int unsigned WIDE_W     = 18;       // Wide port width
  localparam int unsigned NARROW_W   = 9;        // Narrow port width
  localparam int unsigned DEPTH_DEF  = 16;       // Default depth in narrow units
  localparam int unsigned FALL_LAT   = 3;        // Read-clock transitions to first word
  localparam logic [1:0]  LAT_RESET  = 2'h0;
  localparam logic        MODE_STD   = 1'b0;     // Level on mode pin for standard

  // Port control captured at master reset
  typedef struct packed {
    logic in_wide;
    logic out_wide;
    logic async_wr;
    logic async_rd;
    logic fall_thru;
  } bmf_cfg_t;

  // Output word with its width flag
  typedef struct packed {
    logic [WIDE_W-1:0] data;
    logic              wide;
  } bmf_word_t;
endpackage : bmf_pkg

// File: bmf_skid.sv
// Two-entry buffer with valid/ready on both sides.
// Assumes the system clock and synchronous active-low reset of the top.
`timescale 1ns/1ns
module bmf_skid
  import bmf_pkg::*;
#(
  parameter int unsigned W = WIDE_W
) (
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  logic [W-1:0] mem_q [2];
  logic [W-1:0] mem_d [2];
  logic         wp_q, wp_d, rp_q, rp_d;
  logic [1:0]   cnt_q, cnt_d;
  logic         push, pop;

  // Next state of both entries and pointers
  always_comb begin
    push     = in_valid && (cnt_q != 2'h2);
    pop      = out_ready && (cnt_q != 2'h0);
    mem_d    = mem_q;
    wp_d     = wp_q;
    rp_d     = rp_q;
    if (push) begin
      mem_d[wp_q] = in_data;
      wp_d        = ~wp_q;
    end
    if (pop) begin
      rp_d = ~rp_q;
    end
    cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      wp_q  <= wp_d;
      rp_q  <= rp_d;
      cnt_q <= cnt_d;
    end
    mem_q <= mem_d;
  end

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
endmodule : bmf_skid

// File: bmf_port_ctrl.sv
// Write-port and read-port control of a bus-matching FIFO memory.
// Assumes write/read clocks and strobes arrive as synchronous levels on clk_sys.
`timescale 1ns/1ns
module bmf_port_ctrl
  import bmf_pkg::*;
#(
  parameter int unsigned DEPTH = DEPTH_DEF,
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                master_reset_n,
  input  wire logic                input_width_select,
  input  wire logic                output_width_select,
  input  wire logic                async_write_select,
  input  wire logic                async_read_select,
  input  wire logic                timing_mode_serial_in,
  input  wire logic                write_clk,
  input  wire logic                write_enable_n,
  input  wire logic                write_strobe,
  input  wire logic [WIDE_W-1:0]   input_data_bus,
  input  wire logic                read_clk,
  input  wire logic                read_enable_n,
  input  wire logic                read_strobe,
  input  wire logic                read_chip_select_n,
  input  wire logic                output_enable_n,
  output logic [WIDE_W-1:0]        output_data_bus,
  output logic                     output_data_oe,
  output logic                     empty_q,
  output logic                     full_q,
  output logic                     input_stall_q
);
  bmf_cfg_t              cfg_q, cfg_d;
  logic [NARROW_W-1:0]   mem [DEPTH];
  logic [AW-1:0]         wp_q, wp_d, rp_q, rp_d;
  logic [AW:0]           cnt_q, cnt_d;
  logic                  wclk_q, rclk_q, wstb_q, rstb_q;
  logic                  csel_q, csel_d;
  logic [1:0]            lat_q, lat_d;
  logic                  fell_q, fell_d;
  logic [WIDE_W-1:0]     dout_q, dout_d;
  logic                  oe_q, oe_d;
  logic                  wr_ev, rd_ev, wr_ok, rd_ok;
  logic [AW:0]           wr_units, rd_units;
  logic [WIDE_W-1:0]     rd_word;
  logic                  sk_in_ready, sk_out_valid, sk_take;
  logic [WIDE_W-1:0]     sk_out_data;

  // Pointer wrap shared by both ports
  function automatic logic [AW-1:0] inc_ptr(input logic [AW-1:0] p, input logic [AW:0] n);
    logic [AW:0] s;
    s = {1'b0, p} + n;
    if (s >= (AW+1)'(DEPTH)) s = s - (AW+1)'(DEPTH);
    return s[AW-1:0];
  endfunction : inc_ptr

  // Edge detect on write/read clocks and strobes (already synchronous)
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
      wstb_q <= 1'b0;
      rstb_q <= 1'b0;
    end else begin
      wclk_q <= write_clk;
      rclk_q <= read_clk;
      wstb_q <= write_strobe;
      rstb_q <= read_strobe;
    end
  end

  // Write event: clock with enable, or strobe rise with enable held low
  always_comb begin
    if (cfg_q.async_wr) begin
      wr_ev = write_strobe && !wstb_q && !write_enable_n;
    end else begin
      wr_ev = write_clk && !wclk_q && !write_enable_n;
    end
    if (cfg_q.async_rd) begin
      rd_ev = read_strobe && !rstb_q && !read_enable_n;
    end else begin
      rd_ev = read_clk && !rclk_q && !read_enable_n;
    end
  end

  // Memory counts in narrow units; wide ports move two units
  assign wr_units = cfg_q.in_wide ? (AW+1)'(2) : (AW+1)'(1);
  assign rd_units = cfg_q.out_wide ? (AW+1)'(2) : (AW+1)'(1);
  assign wr_ok    = wr_ev && (cnt_q + wr_units <= (AW+1)'(DEPTH));
  assign rd_word  = cfg_q.out_wide
                  ? {mem[inc_ptr(rp_q, (AW+1)'(1))], mem[rp_q]}
                  : {{(WIDE_W-NARROW_W){1'b0}}, mem[rp_q]};
  // Fall-through first word is fetched on the third transition, no request needed
  assign sk_take  = (cnt_q >= rd_units) && sk_in_ready &&
                    (rd_ev || (cfg_q.fall_thru && !fell_q && (read_clk != rclk_q)
                               && lat_q == 2'(FALL_LAT - 1)));
  assign rd_ok    = sk_take;

  // Next pointers, configuration and latency counter
  always_comb begin
    cfg_d  = cfg_q;
    wp_d   = wp_q;
    rp_d   = rp_q;
    cnt_d  = cnt_q;
    lat_d  = lat_q;
    fell_d = fell_q;
    if (!master_reset_n) begin
      cfg_d.in_wide  = input_width_select;
      cfg_d.out_wide = output_width_select;
      cfg_d.async_wr = async_write_select;
      cfg_d.async_rd = async_read_select;
      cfg_d.fall_thru = (timing_mode_serial_in != MODE_STD);
      wp_d   = '0;
      rp_d   = '0;
      cnt_d  = '0;
      lat_d  = LAT_RESET;
      fell_d = 1'b0;
    end else begin
      if (wr_ok) wp_d = inc_ptr(wp_q, wr_units);
      if (rd_ok) rp_d = inc_ptr(rp_q, rd_units);
      cnt_d = cnt_q + (wr_ok ? wr_units : '0) - (rd_ok ? rd_units : '0);
      // Count read-clock transitions while data waits in fall-through
      if (cnt_q == '0 || fell_q) begin
        lat_d = LAT_RESET;
      end else if (read_clk != rclk_q && lat_q != 2'(FALL_LAT - 1)) begin
        lat_d = lat_q + 2'h1;
      end
      if (rd_ok) fell_d = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cfg_q  <= '0;
      wp_q   <= '0;
      rp_q   <= '0;
      cnt_q  <= '0;
      lat_q  <= LAT_RESET;
      fell_q <= 1'b0;
    end else begin
      cfg_q  <= cfg_d;
      wp_q   <= wp_d;
      rp_q   <= rp_d;
      cnt_q  <= cnt_d;
      lat_q  <= lat_d;
      fell_q <= fell_d;
    end
  end

  // Storage array; no reset so it maps to memory
  always_ff @(posedge clk_sys) begin
    if (master_reset_n && wr_ok) begin
      mem[wp_q] <= input_data_bus[NARROW_W-1:0];
      if (cfg_q.in_wide) mem[inc_ptr(wp_q, (AW+1)'(1))] <= input_data_bus[WIDE_W-1:NARROW_W];
    end
  end

  // Two-entry buffer ahead of the output register, which takes its word every cycle
  bmf_skid #(.W(WIDE_W)) u_skid (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n && master_reset_n),
    .in_data   (rd_word),
    .in_valid  (sk_take),
    .in_ready  (sk_in_ready),
    .out_data  (sk_out_data),
    .out_valid (sk_out_valid),
    .out_ready (1'b1)
  );

  // Output register, chip select sample and drive enable
  always_comb begin
    dout_d = dout_q;
    csel_d = csel_q;
    if (cfg_q.async_rd || (read_clk && !rclk_q)) begin
      csel_d = read_chip_select_n;
    end
    if (sk_out_valid) dout_d = sk_out_data;
    oe_d = !output_enable_n && !csel_d;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      dout_q <= '0;
      csel_q <= 1'b1;
      oe_q   <= 1'b0;
    end else begin
      dout_q <= dout_d;
      csel_q <= csel_d;
      oe_q   <= oe_d;
    end
  end

  // Status outputs, registered
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      empty_q       <= 1'b1;
      full_q        <= 1'b0;
      input_stall_q <= 1'b0;
    end else begin
      empty_q       <= (cnt_d == '0);
      full_q        <= (cnt_d + wr_units > (AW+1)'(DEPTH));
      input_stall_q <= !sk_in_ready;
    end
  end

  assign output_data_bus = dout_q;
  assign output_data_oe  = oe_q;

  property p_full_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    (master_reset_n && wr_ev && (cnt_q + wr_units > (AW+1)'(DEPTH))) |=> $stable(wp_q);
  endproperty
  a_full_ignored: assert property (p_full_ignored) else $error("write taken when full");

  property p_empty_ignored;
    @(posedge clk_sys) disable iff (!rst_n)
    (master_reset_n && cnt_q == '0) |=> $stable(rp_q);
  endproperty
  a_empty_ignored: assert property (p_empty_ignored) else $error("read taken when empty");

  property p_mreset_ptrs;
    @(posedge clk_sys) disable iff (!rst_n)
    !master_reset_n |=> (wp_q == '0 && rp_q == '0 && cnt_q == '0);
  endproperty
  a_mreset_ptrs: assert property (p_mreset_ptrs) else $error("pointers not cleared");

  property p_oe_off;
    @(posedge clk_sys) disable iff (!rst_n)
    output_enable_n |=> !output_data_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) else $error("outputs driven while disabled");

  property p_cfg_hold;
    @(posedge clk_sys) disable iff (!rst_n)
    master_reset_n ##1 master_reset_n |-> $stable(cfg_q);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("config changed outside reset");

  sequence s_sync_write;
    master_reset_n && !cfg_q.async_wr && write_clk && !wclk_q && !write_enable_n
      && (cnt_q + wr_units <= (AW+1)'(DEPTH));
  endsequence
  property p_sync_write;
    @(posedge clk_sys) disable iff (!rst_n)
    s_sync_write |=> (cnt_q == $past(cnt_q) + $past(wr_units) - ($past(rd_ok) ? $past(rd_units) : '0));
  endproperty
  a_sync_write: assert property (p_sync_write) else $error("sync write not stored");

  property p_width_latch;
    @(posedge clk_sys) disable iff (!rst_n)
    !master_reset_n |=> (cfg_q.in_wide == $past(input_width_select)
                         && cfg_q.out_wide == $past(output_width_select));
  endproperty
  a_width_latch: assert property (p_width_latch) else $error("width not latched");

  property p_std_no_fall;
    @(posedge clk_sys) disable iff (!rst_n)
    (master_reset_n && !cfg_q.fall_thru && !rd_ev) |-> !sk_take;
  endproperty
  a_std_no_fall: assert property (p_std_no_fall) else $error("standard mode read w/o enable");
endmodule : bmf_port_ctrl

// File: bmf_far_end.sv
// Far-side model: upstream writer and downstream reader of the FIFO ports.
// Assumes clk_sys from the bench; all changes land just after a rising edge.
`timescale 1ns/1ns
module bmf_far_end
  import bmf_pkg::*;
(
  input  wire logic        clk_sys,
  output logic             write_clk,
  output logic             write_enable_n,
  output logic             write_strobe,
  output logic [WIDE_W-1:0] input_data_bus,
  output logic             read_clk,
  output logic             read_enable_n,
  output logic             read_strobe
);
  // Idle levels at time zero
  initial begin
    {write_clk, write_strobe, read_clk, read_strobe} = 4'h0;
    {write_enable_n, read_enable_n} = 2'h3;
    input_data_bus = '0;
  end

  // One write; in strobe mode the enable stays low throughout
  task automatic put(input logic asy, input logic [WIDE_W-1:0] d);
    @(posedge clk_sys);
    input_data_bus <= d;
    write_enable_n <= 1'b0;
    if (asy) write_strobe <= 1'b1;
    else write_clk <= 1'b1;
    @(posedge clk_sys);
    {write_clk, write_strobe} <= 2'h0;
    write_enable_n <= !asy;
    input_data_bus <= ~d; // Released bus never shows the last word
  endtask : put

  // One read-port rise; en low gives a bare clock cycle, except with asy set, where the strobe is always sent with enable low
  task automatic get(input logic asy, input logic en);
    @(posedge clk_sys);
    read_enable_n <= !(en || asy);
    if (asy) read_strobe <= 1'b1;
    else read_clk <= 1'b1;
    @(posedge clk_sys);
    {read_clk, read_strobe} <= 2'h0;
    read_enable_n <= !asy;
  endtask : get
endmodule : bmf_far_end

// File: bus_matching_fifo_port_control_bench.sv
// Self-checking bench for the FIFO port control.
// Assumes the far-end model in bmf_far_end.sv; depth shrunk to 4 units.
`timescale 1ns/1ns
module bus_matching_fifo_port_control_bench;
  import bmf_pkg::*;
  logic clk_sys, rst_n, master_reset_n, input_width_select, output_width_select;
  logic async_write_select, async_read_select, timing_mode_serial_in;
  logic write_clk, write_enable_n, write_strobe, read_clk, read_enable_n;
  logic read_strobe, read_chip_select_n, output_enable_n;
  logic output_data_oe, empty_q, full_q, input_stall_q;
  logic [WIDE_W-1:0] input_data_bus, output_data_bus;
  int num_errors = 0;
  int check_count = 0;

  bmf_port_ctrl #(.DEPTH(4)) dut_u (.clk_sys, .rst_n, .master_reset_n,
    .input_width_select, .output_width_select, .async_write_select,
    .async_read_select, .timing_mode_serial_in, .write_clk, .write_enable_n,
    .write_strobe, .input_data_bus, .read_clk, .read_enable_n, .read_strobe,
    .read_chip_select_n, .output_enable_n, .output_data_bus, .output_data_oe,
    .empty_q, .full_q, .input_stall_q);
  bmf_far_end far_u (.clk_sys, .write_clk, .write_enable_n, .write_strobe,
    .input_data_bus, .read_clk, .read_enable_n, .read_strobe);

  // 50 ns period
  initial clk_sys = 1'b0;
  always #25 clk_sys = ~clk_sys;

  task automatic check(input logic [WIDE_W-1:0] seen, input logic [WIDE_W-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize;
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : tick

  // Straps held through a master reset window
  task automatic mreset(input logic [4:0] s);
    @(posedge clk_sys);
    {input_width_select, output_width_select, async_write_select} <= s[4:2];
    {async_read_select, timing_mode_serial_in} <= s[1:0];
    master_reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    master_reset_n <= 1'b1;
    tick(1);
  endtask : mreset

  // Read event, then data three edges later
  task automatic rdchk(input logic asy, input logic [WIDE_W-1:0] exp);
    far_u.get(asy, 1'b1);
    tick(3);
    check(output_data_bus, exp);
  endtask : rdchk

  initial begin
    {rst_n, master_reset_n, read_chip_select_n, output_enable_n} = 4'h3;
    {input_width_select, output_width_select, async_write_select} = 3'h0;
    {async_read_select, timing_mode_serial_in} = 2'h0;
    rst_n = 1'b0;
    // Release on an edge so the first sampled edge is clean
    repeat (5) @(posedge clk_sys);
    rst_n              <= 1'b1;
    read_chip_select_n <= 1'b0;
    output_enable_n    <= 1'b0;
    #1;
    check(WIDE_W'({empty_q, full_q, output_data_oe, input_stall_q}), 18'h8);
    check(output_data_bus, 18'h0);
    $display("test reset done");
    // Wide in, wide out, standard timing; back-to-back writes
    mreset(5'h18);
    far_u.put(1'b0, 18'h2a5c3);
    far_u.put(1'b0, 18'h15a3c);
    tick(1);
    check(WIDE_W'(empty_q), 18'h0);
    far_u.get(1'b0, 1'b0);
    far_u.get(1'b0, 1'b0);
    tick(4);
    check(output_data_bus, 18'h0);
    rdchk(1'b0, 18'h2a5c3);
    rdchk(1'b0, 18'h15a3c);
    check(WIDE_W'(empty_q), 18'h1);
    $display("test wide done");
    // Wide in, narrow out: low half first
    mreset(5'h10);
    far_u.put(1'b0, 18'h2a5c3);
    rdchk(1'b0, 18'h001c3);
    rdchk(1'b0, 18'h00152);
    $display("test matching done");
    // Narrow both sides: fill past full, drain past empty
    mreset(5'h00);
    for (int i = 0; i < 4; i++) far_u.put(1'b0, 18'(9'h1a0 + i));
    tick(1);
    check(WIDE_W'(full_q), 18'h1);
    far_u.put(1'b0, 18'h000ff);
    for (int i = 0; i < 4; i++) rdchk(1'b0, 18'(9'h1a0 + i));
    check(WIDE_W'(empty_q), 18'h1);
    rdchk(1'b0, 18'h001a3);
    $display("test full empty done");
    // Output enable and sampled chip select, driven on clock edges
    @(posedge clk_sys);
    output_enable_n <= 1'b1;
    tick(2);
    check(WIDE_W'(output_data_oe), 18'h0);
    @(posedge clk_sys);
    output_enable_n <= 1'b0;
    tick(2);
    check(WIDE_W'(output_data_oe), 18'h1);
    @(posedge clk_sys);
    read_chip_select_n <= 1'b1;
    far_u.get(1'b0, 1'b0);
    tick(2);
    check(WIDE_W'(output_data_oe), 18'h0);
    @(posedge clk_sys);
    read_chip_select_n <= 1'b0;
    far_u.get(1'b0, 1'b0);
    tick(2);
    check(WIDE_W'(output_data_oe), 18'h1);
    $display("test three-state done");
    // Master reset with data held clears the pointers
    far_u.put(1'b0, 18'h00055);
    tick(1);
    check(WIDE_W'(empty_q), 18'h0);
    mreset(5'h18);
    check(WIDE_W'({empty_q, full_q}), 18'h2);
    $display("test master reset done");
    // Strobe ports, standard timing as the async reader must pick
    mreset(5'h1e);
    far_u.put(1'b1, 18'h3f00f);
    far_u.put(1'b1, 18'h0aaaa);
    rdchk(1'b1, 18'h3f00f);
    rdchk(1'b1, 18'h0aaaa);
    // Back to clocked ports: a strobe must now do nothing
    mreset(5'h18);
    far_u.put(1'b1, 18'h01234);
    tick(2);
    check(WIDE_W'(empty_q), 18'h1);
    $display("test async done");
    // Fall-through: first word shows without a read enable
    mreset(5'h19);
    far_u.put(1'b0, 18'h12345);
    far_u.get(1'b0, 1'b0);
    // Two transitions only: the old word must still stand
    tick(3);
    check(output_data_bus, 18'h0aaaa);
    far_u.get(1'b0, 1'b0);
    for (int i = 0; i < 12 && output_data_bus !== 18'h12345; i++) tick(1);
    check(output_data_bus, 18'h12345);
    $display("test fall-through done");
    summarize();
  end
endmodule : bus_matching_fifo_port_control_bench
